/* File: udef_defines.vh */
`ifndef UDEF_DEFINES_VH
`define UDEF_DEFINES_VH

// ==========================================
// Register map, 16-bit words on the word port
`define UDEF_ADDR_W 16
`define UDEF_DEV1_STATUS_ADDR 16'hC090
`define UDEF_DEV1_FRAME_ADDR 16'hC092
`define UDEF_DEV2_STATUS_ADDR 16'hC0B0
`define UDEF_DEV2_FRAME_ADDR 16'hC0B2

// ==========================================
// Status register fields
`define UDEF_ST_VBUS 15
`define UDEF_ST_ID 14
`define UDEF_ST_MARK 9
`define UDEF_ST_BUSRST 8
`define UDEF_ST_EP_MSB 7
`define UDEF_ST_EP_LSB 0
`define UDEF_DEV1_ST_MASK 16'hC3FF
`define UDEF_DEV2_ST_MASK 16'h03FF

// ==========================================
// Frame-number register fields
`define UDEF_FR_TOFLAG 15
`define UDEF_FR_CNT_MSB 14
`define UDEF_FR_CNT_LSB 12
`define UDEF_FR_FRAME_MSB 10
`define UDEF_FR_FRAME_LSB 0
`define UDEF_TOCNT_MAX 3'h7

// ==========================================
// Timing
`define UDEF_CLK_MHZ 200
`define UDEF_TICK_MHZ 12
`define UDEF_TICK_DIV_W 5
`define UDEF_PIN_FILL 2'h3
`define UDEF_MARK_TIMEOUT_RESET 14'h2EE0
`define UDEF_MARK_TIMEOUT_W 14

`endif

/* File: udef_mark_timer.v */
`timescale 1ns/10ps
`include "udef_defines.vh"

// ==========================================
// Frame-marker watchdog: 12 MHz down counter, one-cycle pulse on expiry
module udef_mark_timer #(
  parameter CNT_W = `UDEF_MARK_TIMEOUT_W,
  parameter [CNT_W-1:0] LOAD = `UDEF_MARK_TIMEOUT_RESET
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  // Control
  input wire marker,
  // Status
  output reg expire_pulse,
  output wire [CNT_W-1:0] count
);

  // 200/12 is not whole; fractional accumulator keeps the mean rate exact
  localparam [`UDEF_TICK_DIV_W+3:0] ACC_MAX = `UDEF_CLK_MHZ;
  localparam [`UDEF_TICK_DIV_W+3:0] STEP = `UDEF_TICK_MHZ;
  reg [`UDEF_TICK_DIV_W+3:0] acc_r;
  reg [CNT_W-1:0] cnt_r;
  wire [`UDEF_TICK_DIV_W+3:0] acc_sum;
  wire tick;

  assign acc_sum = acc_r + STEP;
  assign tick = (acc_sum >= ACC_MAX);
  assign count = cnt_r;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= {(`UDEF_TICK_DIV_W+4){1'b0}};
      cnt_r <= LOAD;
      expire_pulse <= 1'b0;
    end else if (clk_en) begin
      acc_r <= tick ? acc_sum - ACC_MAX : acc_sum;
      expire_pulse <= 1'b0;
      if (marker) begin
        cnt_r <= LOAD;
      end else if (tick) begin
        if (cnt_r == {CNT_W{1'b0}}) begin
          // Expired: raise event and rearm for the next interval
          expire_pulse <= 1'b1;
          cnt_r <= LOAD;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule // udef_mark_timer

/* File: udef_event_flags.v */
`timescale 1ns/10ps
`include "udef_defines.vh"

// ==========================================
// Operation
// - With enable set, bus-power flag bit 15 sets on either 4.4V crossing.
// - With enable set, ID flag bit 14 sets on either ID pin edge.
// - Bits 15 and 14 exist only in device 1; reserved in device 2.
// - Frame-marker flag bit 9 sets on each SOF or EOP received.
// - Bus-reset flag bit 8 sets whenever bus reset is detected.
// - Bits 7..0 set on endpoint ACK, STALL, timeout or IN/OUT exception.
// - With endpoint NAK enable set, a sent NAK also sets its flag.
// - Each flag reads 1 when its event fired, else 0.
// - Frame register is read-only, device 1 at C092, device 2 at C0B2.
// - Full speed: SOF frame number captured into bits 10..0.
// - Low speed: frame field unused and not updated.
// - On timeout the frame field keeps the last received frame number.
// - Frame register bit 15 reads 1 after a marker timeout.
// - Bits 14..12 count timeouts upward from 0 to 7.
// - Timeout count returns to zero on any SOF or EOP.
// - Timeout count changes only while timeout enable is set.
// - Writing 1 to a status flag clears it; writing 0 leaves it.
// - Status register at C090 for device 1, C0B0 for device 2.
// - Marker watchdog decrements at 12 MHz, loads 0x2EE0, expiry is timeout.
module udef_event_flags #(
  parameter N_EP = 8,
  parameter FRAME_W = 11,
  parameter [`UDEF_MARK_TIMEOUT_W-1:0] MARK_LOAD = `UDEF_MARK_TIMEOUT_RESET
) (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  // Register word port
  input wire reg_sel,
  input wire reg_wr,
  input wire [`UDEF_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // Enables from outside this block
  input wire vbus_evt_en,
  input wire id_evt_en,
  input wire timeout_evt_en,
  input wire [N_EP-1:0] nak_evt_en,
  // Dual-role port pins, device 1 only
  input wire vbus_above_pin,
  input wire id_pin,
  // Device 1 protocol events, one-cycle pulses
  input wire d1_marker,
  input wire d1_sof_valid,
  input wire [FRAME_W-1:0] d1_sof_frame,
  input wire d1_full_speed,
  input wire d1_bus_reset,
  input wire [N_EP-1:0] d1_ep_done,
  input wire [N_EP-1:0] d1_ep_nak,
  // Device 2 protocol events, one-cycle pulses
  input wire d2_marker,
  input wire d2_sof_valid,
  input wire [FRAME_W-1:0] d2_sof_frame,
  input wire d2_full_speed,
  input wire d2_bus_reset,
  input wire [N_EP-1:0] d2_ep_done,
  input wire [N_EP-1:0] d2_ep_nak,
  // Status views
  output wire [15:0] dev1_status,
  output wire [15:0] dev2_status,
  output wire [15:0] dev1_frame,
  output wire [15:0] dev2_frame
);

  // ==========================================
  // Helpers
  function [15:0] status_next;
    input [15:0] cur;
    input [15:0] set_v;
    input clr_en;
    input [15:0] clr_v;
    input [15:0] mask;
    begin
      // Set beats a same-cycle clear so no event is lost
      status_next = ((cur & ~(clr_en ? clr_v : 16'h0000)) | set_v) & mask;
    end
  endfunction

  function [2:0] tocnt_next;
    input [2:0] cur;
    input marker;
    input expire;
    input en;
    begin
      if (!en)
        tocnt_next = cur;
      else if (marker)
        tocnt_next = 3'h0;
      else if (expire && cur != `UDEF_TOCNT_MAX)
        tocnt_next = cur + 3'h1;
      else
        tocnt_next = cur;
    end
  endfunction

  function reg_write_hit;
    input sel;
    input wr;
    input [`UDEF_ADDR_W-1:0] addr;
    input [`UDEF_ADDR_W-1:0] target;
    begin
      // Shared by both status decodes
      reg_write_hit = sel & wr & (addr == target);
    end
  endfunction

  // ==========================================
  // Pin synchronisers and edge detect
  reg [1:0] vbus_sync_r;
  reg [1:0] id_sync_r;
  reg vbus_prev_r;
  reg id_prev_r;
  reg [1:0] pins_fill_r;
  wire pins_valid;
  wire vbus_edge;
  wire id_edge;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vbus_sync_r <= 2'h0;
      id_sync_r <= 2'h0;
      vbus_prev_r <= 1'b0;
      id_prev_r <= 1'b0;
    end else if (clk_en) begin
      vbus_sync_r <= {vbus_sync_r[0], vbus_above_pin};
      id_sync_r <= {id_sync_r[0], id_pin};
      vbus_prev_r <= vbus_sync_r[1];
      id_prev_r <= id_sync_r[1];
    end
  end

  // Wait until both sync stages and the edge register hold real samples; a pin idling high is no edge
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pins_fill_r <= 2'h0;
    end else if (clk_en && pins_fill_r != `UDEF_PIN_FILL) begin
      pins_fill_r <= pins_fill_r + 2'h1;
    end
  end

  assign pins_valid = (pins_fill_r == `UDEF_PIN_FILL);
  assign vbus_edge = pins_valid & (vbus_sync_r[1] ^ vbus_prev_r);
  assign id_edge = pins_valid & (id_sync_r[1] ^ id_prev_r);

  // ==========================================
  // Marker watchdogs
  wire d1_expire;
  wire d2_expire;

  // Reload is fixed per build; there is no runtime count register here
  udef_mark_timer #(
    .CNT_W(`UDEF_MARK_TIMEOUT_W),
    .LOAD(MARK_LOAD)
  ) u_d1_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .marker(d1_marker),
    .expire_pulse(d1_expire),
    .count()
  );

  udef_mark_timer #(
    .CNT_W(`UDEF_MARK_TIMEOUT_W),
    .LOAD(MARK_LOAD)
  ) u_d2_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .marker(d2_marker),
    .expire_pulse(d2_expire),
    .count()
  );

  // ==========================================
  // Status registers
  reg [15:0] d1_status_r;
  reg [15:0] d2_status_r;
  reg [15:0] d1_set;
  reg [15:0] d2_set;
  wire d1_st_wr;
  wire d2_st_wr;

  assign d1_st_wr = reg_write_hit(reg_sel, reg_wr, reg_addr, `UDEF_DEV1_STATUS_ADDR);
  assign d2_st_wr = reg_write_hit(reg_sel, reg_wr, reg_addr, `UDEF_DEV2_STATUS_ADDR);

  always @* begin
    d1_set = 16'h0000;
    d1_set[`UDEF_ST_VBUS] = vbus_evt_en & vbus_edge;
    d1_set[`UDEF_ST_ID] = id_evt_en & id_edge;
    d1_set[`UDEF_ST_MARK] = d1_marker;
    d1_set[`UDEF_ST_BUSRST] = d1_bus_reset;
    d1_set[`UDEF_ST_EP_MSB:`UDEF_ST_EP_LSB] = d1_ep_done | (d1_ep_nak & nak_evt_en);
    d2_set = 16'h0000;
    d2_set[`UDEF_ST_MARK] = d2_marker;
    d2_set[`UDEF_ST_BUSRST] = d2_bus_reset;
    d2_set[`UDEF_ST_EP_MSB:`UDEF_ST_EP_LSB] = d2_ep_done | (d2_ep_nak & nak_evt_en);
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d1_status_r <= 16'h0000;
    end else if (clk_en) begin
      d1_status_r <= status_next(d1_status_r, d1_set, d1_st_wr, reg_wdata, `UDEF_DEV1_ST_MASK);
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d2_status_r <= 16'h0000;
    end else if (clk_en) begin
      // Device 2 mask holds bits 15 and 14 at zero
      d2_status_r <= status_next(d2_status_r, d2_set, d2_st_wr, reg_wdata, `UDEF_DEV2_ST_MASK);
    end
  end

  // ==========================================
  // Frame-number registers, hardware-written only
  reg [FRAME_W-1:0] d1_frame_r;
  reg [FRAME_W-1:0] d2_frame_r;
  reg [2:0] d1_tocnt_r;
  reg [2:0] d2_tocnt_r;
  reg d1_toflag_r;
  reg d2_toflag_r;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d1_frame_r <= {FRAME_W{1'b0}};
      d1_tocnt_r <= 3'h0;
      d1_toflag_r <= 1'b0;
    end else if (clk_en) begin
      // Timeouts leave the frame field untouched
      if (d1_sof_valid && d1_full_speed)
        d1_frame_r <= d1_sof_frame;
      d1_tocnt_r <= tocnt_next(d1_tocnt_r, d1_marker, d1_expire, timeout_evt_en);
      if (d1_marker)
        d1_toflag_r <= 1'b0;
      else if (d1_expire)
        d1_toflag_r <= 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d2_frame_r <= {FRAME_W{1'b0}};
      d2_tocnt_r <= 3'h0;
      d2_toflag_r <= 1'b0;
    end else if (clk_en) begin
      // Timeouts leave the frame field untouched
      if (d2_sof_valid && d2_full_speed)
        d2_frame_r <= d2_sof_frame;
      d2_tocnt_r <= tocnt_next(d2_tocnt_r, d2_marker, d2_expire, timeout_evt_en);
      if (d2_marker)
        d2_toflag_r <= 1'b0;
      else if (d2_expire)
        d2_toflag_r <= 1'b1;
    end
  end

  assign dev1_status = d1_status_r;
  assign dev2_status = d2_status_r;
  assign dev1_frame = {d1_toflag_r, d1_tocnt_r, 1'b0, d1_frame_r};
  assign dev2_frame = {d2_toflag_r, d2_tocnt_r, 1'b0, d2_frame_r};

  // ==========================================
  // Read path; writes to frame addresses are ignored
  // Registered read data; one cycle of latency keeps the output glitch-free
  reg [15:0] rd_mux;
  wire rd_take;

  assign rd_take = reg_sel & ~reg_wr;

  always @* begin
    case (reg_addr)
      `UDEF_DEV1_STATUS_ADDR: rd_mux = d1_status_r;
      `UDEF_DEV2_STATUS_ADDR: rd_mux = d2_status_r;
      `UDEF_DEV1_FRAME_ADDR: rd_mux = dev1_frame;
      `UDEF_DEV2_FRAME_ADDR: rd_mux = dev2_frame;
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en && rd_take) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule // udef_event_flags

/* File: udef_chk.sv */
`timescale 1ns/10ps
// ==========
// Flag and frame checker
module udef_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire clk_en,
  // Register port
  input wire reg_sel,
  input wire reg_wr,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  // Events
  input wire timeout_evt_en,
  input wire [7:0] nak_evt_en,
  input wire d1_marker,
  input wire d1_sof_valid,
  input wire [10:0] d1_sof_frame,
  input wire d1_full_speed,
  input wire d1_bus_reset,
  input wire [7:0] d1_ep_done,
  input wire [7:0] d1_ep_nak,
  // Views
  input wire [15:0] dev1_status,
  input wire [15:0] dev2_status,
  input wire [15:0] dev1_frame
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Same-edge bus reset excluded, set wins
  sequence clr_rst_s;
    clk_en && reg_sel && reg_wr && reg_addr == 16'hC090 && reg_wdata[8] && !d1_bus_reset;
  endsequence
  sequence frame_wr_s;
    clk_en && reg_sel && reg_wr && reg_addr == 16'hC092 && !d1_sof_valid;
  endsequence
  mark_flag_a: assert property (clk_en && d1_marker |=> dev1_status[9])
    else $error("marker flag");
  ep_done_a: assert property (clk_en && |d1_ep_done |=> (~dev1_status[7:0] & $past(d1_ep_done)) == 8'h00)
    else $error("endpoint flag");
  nak_flag_a: assert property (clk_en && |(d1_ep_nak & nak_evt_en) |=>
    (~dev1_status[7:0] & $past(d1_ep_nak & nak_evt_en)) == 8'h00)
    else $error("nak flag");
  resv_zero_a: assert property (dev2_status[15:14] == 2'h0 && dev1_status[13:10] == 4'h0)
    else $error("reserved bits");
  frame_cap_a: assert property (clk_en && d1_sof_valid && d1_full_speed |=> dev1_frame[10:0] == $past(d1_sof_frame))
    else $error("frame capture");
  cnt_clr_a: assert property (clk_en && d1_marker && timeout_evt_en |=> dev1_frame[14:12] == 3'h0)
    else $error("count clear");
  cnt_hold_a: assert property (!timeout_evt_en |=> $stable(dev1_frame[14:12]))
    else $error("count hold");
  rst_clr_a: assert property (clr_rst_s |=> !dev1_status[8])
    else $error("write one clear");
  frame_ro_a: assert property (frame_wr_s |=> $stable(dev1_frame[10:0]))
    else $error("frame written");
  sequence sat_hold_s;
    dev1_frame[14:12] == 3'h7 && !(clk_en && d1_marker);
  endsequence
  cnt_sat_a: assert property (sat_hold_s |=> dev1_frame[14:12] == 3'h7)
    else $error("count saturate");
  toflag_clr_a: assert property (clk_en && d1_marker |=> !dev1_frame[15])
    else $error("timeout flag clear");
endmodule // udef_chk
bind udef_event_flags udef_chk chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .reg_sel(reg_sel),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .timeout_evt_en(timeout_evt_en),
  .nak_evt_en(nak_evt_en), .d1_marker(d1_marker), .d1_sof_valid(d1_sof_valid), .d1_sof_frame(d1_sof_frame),
  .d1_full_speed(d1_full_speed), .d1_bus_reset(d1_bus_reset), .d1_ep_done(d1_ep_done), .d1_ep_nak(d1_ep_nak),
  .dev1_status(dev1_status), .dev2_status(dev2_status), .dev1_frame(dev1_frame));

/* File: udef_host_model.sv */
`timescale 1ns/10ps
// ==========
// Host side, one event per request
module udef_host_model (
  // Clock and request
  input wire ref_clk,
  input wire [2:0] kind,
  input wire [7:0] ep,
  // Events
  output wire marker,
  output wire sof_valid,
  output wire [10:0] sof_frame,
  output wire bus_reset,
  output wire [7:0] ep_done,
  output wire [7:0] ep_nak
);
  // Starts near the top so the 11-bit wrap is crossed
  reg [10:0] frame_r = 11'h7F0;
  always @(posedge ref_clk) if (kind == 3'h1) frame_r <= frame_r + 11'h001;
  assign marker = kind == 3'h1 || kind == 3'h2;
  assign sof_valid = kind == 3'h1;
  // Frame bus never holds a stale number
  assign sof_frame = sof_valid ? frame_r : ~frame_r;
  assign bus_reset = kind == 3'h3;
  assign ep_done = kind == 3'h4 ? ep : 8'h00;
  assign ep_nak = kind == 3'h5 ? ep : 8'h00;
endmodule // udef_host_model

/* File: usb_device_event_flags_frame_tracker_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons = comparisons + 1; if ((a) !== (b)) begin fails = fails + 1; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
// ==========
// Bench
module usb_device_event_flags_frame_tracker_tb;
  reg ref_clk = 0, rstn = 0, sel = 0, wr = 0, vb = 0, idp = 0, dv = 0, ven = 0, ien = 0, ten = 0, fs = 1;
  reg [15:0] addr = 0, wd = 0, s1 = 0, s2 = 0, f1 = 0, f2 = 0;
  reg [7:0] nen = 0, ep = 0;
  reg [2:0] kind = 0, tc = 0;
  reg [10:0] hf = 11'h7F0;
  wire [15:0] rd;
  wire mk, sv, br;
  wire [10:0] sf;
  wire [7:0] dn, nk;
  wire [15:0] o1, o2, g1, g2;
  integer seed = 47753, fails = 0, comparisons = 0, cyc = 0, i, r;
  udef_host_model host (.ref_clk(ref_clk), .kind(kind), .ep(ep), .marker(mk), .sof_valid(sv), .sof_frame(sf),
    .bus_reset(br), .ep_done(dn), .ep_nak(nk));
  // Watchdog shortened so the timeout scenario fits the run
  udef_event_flags #(.MARK_LOAD(14'h0040)) uut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1), .reg_sel(sel),
    .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd), .vbus_evt_en(ven), .id_evt_en(ien),
    .timeout_evt_en(ten), .nak_evt_en(nen), .vbus_above_pin(vb), .id_pin(idp), .d1_marker(mk & ~dv),
    .d1_sof_valid(sv & ~dv), .d1_sof_frame(sf), .d1_full_speed(fs), .d1_bus_reset(br & ~dv),
    .d1_ep_done(dn & {8{~dv}}), .d1_ep_nak(nk & {8{~dv}}), .d2_marker(mk & dv), .d2_sof_valid(sv & dv),
    .d2_sof_frame(sf), .d2_full_speed(fs), .d2_bus_reset(br & dv), .d2_ep_done(dn & {8{dv}}),
    .d2_ep_nak(nk & {8{dv}}), .dev1_status(o1), .dev2_status(o2), .dev1_frame(g1), .dev2_frame(g2));
  always #2.5 ref_clk = ~ref_clk;
  // Run needs about 12000 cycles
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end
  function [15:0] bits(input [2:0] k, input [7:0] m, input [7:0] en);
    case (k)
      3'h1, 3'h2: bits = 16'h0200;
      3'h3: bits = 16'h0100;
      3'h4: bits = {8'h00, m};
      3'h5: bits = {8'h00, m & en};
      default: bits = 16'h0000;
    endcase
  endfunction
  task test_done;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task acc(input w, input [15:0] a, input [15:0] d);
    begin
      @(negedge ref_clk);
      sel = 1'b1;
      wr = w;
      addr = a;
      wd = d;
      @(negedge ref_clk);
      sel = 1'b0;
    end
  endtask
  task chk(input [15:0] a, input [15:0] e);
    begin
      acc(1'b0, a, 16'h0000);
      `CHK(rd, e)
    end
  endtask
  task ev(input [2:0] k, input d, input [7:0] m);
    begin
      @(negedge ref_clk);
      kind = k;
      dv = d;
      ep = m;
      @(negedge ref_clk);
      kind = 3'h0;
      if (d) s2 = s2 | bits(k, m, nen);
      else s1 = s1 | bits(k, m, nen);
      if (k == 3'h1 && d && fs) f2[10:0] = hf;
      if (k == 3'h1 && !d && fs) f1[10:0] = hf;
      if ((k == 3'h1 || k == 3'h2) && d) f2[15:12] = {1'b0, ten ? 3'h0 : f2[14:12]};
      if ((k == 3'h1 || k == 3'h2) && !d) f1[15:12] = {1'b0, ten ? 3'h0 : f1[14:12]};
      if (k == 3'h1) hf = hf + 11'h001;
    end
  endtask
  task pins(input w, input ve, input ie);
    begin
      @(negedge ref_clk);
      ven = ve;
      ien = ie;
      if (w) vb = ~vb;
      else idp = ~idp;
      repeat (6) @(negedge ref_clk);
      if (w && ve) s1 = s1 | 16'h8000;
      if (!w && ie) s1 = s1 | 16'h4000;
    end
  endtask
  task rdall;
    begin
      chk(16'hC090, s1);
      chk(16'hC0B0, s2);
      chk(16'hC092, f1);
      chk(16'hC0B2, f2);
      `CHK(({o1, o2, g1, g2}), ({s1, s2, f1, f2}))
    end
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1;
    rdall;
    for (i = 0; i < 400; i = i + 1) begin
      r = $random(seed);
      ten = r[8];
      fs = r[9] | r[10];
      nen = r[23:16];
      case (r[2:0])
        3'h0: begin
          acc(1'b1, r[3] ? 16'hC0B0 : 16'hC090, r[31:16] & (r[3] ? 16'h03FF : 16'hC3FF));
          if (r[3]) s2 = s2 & ~r[31:16];
          else s1 = s1 & ~r[31:16];
        end
        3'h6: rdall;
        3'h7: pins(r[3], r[4], r[5]);
        default: ev(r[2:0], r[3], r[15:8]);
      endcase
    end
    // Reads fall midway between expiries, about 1083 cycles apart
    ten = 1'b1;
    ev(3'h2, 1'b0, 8'h00);
    ev(3'h2, 1'b1, 8'h00);
    repeat (540) @(negedge ref_clk);
    rdall;
    for (i = 1; i < 10; i = i + 1) begin
      ten = (i != 3);
      repeat (1075) @(negedge ref_clk);
      if (ten && tc != 3'h7) tc = tc + 3'h1;
      f1[15:12] = {1'b1, tc};
      f2[15:12] = {1'b1, tc};
      rdall;
    end
    ev(3'h2, 1'b0, 8'h00);
    ev(3'h2, 1'b1, 8'h00);
    rdall;
    acc(1'b1, 16'hC092, 16'hFFFF);
    chk(16'hC092, f1);
    chk(16'hC094, 16'h0000);
    rdall;
    test_done;
  end
endmodule // usb_device_event_flags_frame_tracker_tb
